/* core/nvram_pkg.sv */
// shared constants and types for the two-wire memory slave and its master
package nvram_pkg;

  // ==========================================================
  // memory geometry
  localparam int MEM_WORDS = 131072;           // bytes in the array
  localparam int ADDR_W    = 17;               // byte address width
  localparam int BYTE_W    = 8;                // bits per transfer unit
  localparam int ACK_SLOT  = 8;                // bit index of the ninth clock

  // ==========================================================
  // address word layout (first byte after a start, msb first)
  localparam int AW_TYPE_LSB = 4;              // 4-bit type code
  localparam int AW_SELH_BIT = 3;              // higher select pin
  localparam int AW_SELL_BIT = 2;              // lower select pin
  localparam int AW_TOP_BIT  = 1;              // top memory address bit
  localparam int AW_DIR_BIT  = 0;              // 0 write, 1 read

  // ==========================================================
  // timing: our clock and the serial clock we generate
  localparam int CLK_PERIOD_NS = 25;           // 40 mhz system clock
  localparam int SCL_PERIOD_NS = 1000;         // 1 mhz, fast-mode-plus max
  // longest half period rounds down, never below one cycle
  localparam int SCL_HALF_RAW  = SCL_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int SCL_HALF_CYC  = (SCL_HALF_RAW < 1) ? 1 : SCL_HALF_RAW;

  // ==========================================================
  // master register map (apb byte addresses)
  localparam logic [11:0] CMD_OFF  = 12'h000;  // command, write only
  localparam logic [11:0] TXD_OFF  = 12'h004;  // byte to send
  localparam logic [11:0] STAT_OFF = 12'h008;  // status, read only
  localparam int CMD_OP_LSB    = 0;            // 2-bit opcode
  localparam int CMD_ACK_BIT   = 2;            // level sent on ninth clock
  localparam int STAT_BUSY_BIT = 0;            // operation in flight
  localparam int STAT_NACK_BIT = 1;            // ninth bit seen high
  localparam int STAT_RX_LSB   = 8;            // last received byte
  localparam logic [8:0] TXD_RST = 9'h1ff;     // idle shift: line released

  // ==========================================================
  // master operations and slave states
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} op_t;
  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_RACK} slv_state_t;

endpackage : nvram_pkg

/* core/two_wire_if.sv */
// two-wire bus carrier joining the master and the memory slave
`timescale 1ns/100ps
interface two_wire_if;

  logic scl;                // serial clock, driven only by the master
  logic dev_sda_out;        // slave data drive value (always low)
  logic dev_sda_oe_n;       // slave drives data line when low
  logic mst_sda_out;        // master data drive value (always low)
  logic mst_sda_oe_n;       // master drives data line when low
  logic sda;                // resolved data line with pull-up

  // open drain wired-and: any enabled low driver wins, else pulled high
  assign sda = ~((~dev_sda_oe_n & ~dev_sda_out) |
                 (~mst_sda_oe_n & ~mst_sda_out));

  modport device (input scl, input sda,
                  output dev_sda_out, output dev_sda_oe_n);
  modport master (output scl, input sda,
                  output mst_sda_out, output mst_sda_oe_n);

endinterface : two_wire_if

/* core/line_sync.sv */
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/100ps
module line_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;     // first stage, read only by the second

  // ==========================================================
  // per-bit stages; a floating input takes the else branch and
  // so reads as low, like an internal pull-down
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (reset) begin
        meta_q[i] <= 1'b0;
        q[i]      <= 1'b0;
      end else begin
        if (d[i]) begin
          meta_q[i] <= 1'b1;
        end else begin
          meta_q[i] <= 1'b0;
        end
        q[i] <= meta_q[i];
      end
    end
  end

endmodule : line_sync

/* core/nvram_slave.sv */
// two-wire slave port of a 128k x 8 nonvolatile memory
`timescale 1ns/100ps

// Operation
// - array of 131072 bytes, serial access only
// - master keeps clock within speed limits
// - respond only when select code matches pins
// - floating select pin reads as low
// - data line driven low only, else released
// - sample on clock rise, drive on fall
// - write-lock high blocks every array write
// - reads work whatever write-lock says
// - floating write-lock reads as low
// - master starts transfers and supplies clock
// - data changes only while clock low
// - data fall with clock high is start
// - data rise with clock high is stop
// - stop ends transfer, enters standby
// - writes commit at once, no wait
// - eight-bit bytes, receiver acks on ninth
// - transmitter releases line on ninth clock
// - stop before acknowledge abandons to standby
// - after a not-acknowledge the bus is released
// - first byte: type, select, top bit, direction
// - direction 0 writes, 1 reads
// - type or select mismatch: no ack, standby
module nvram_slave
  import nvram_pkg::*;
#(
  parameter logic [3:0] TYPE_CODE = 4'h6       // arbitrary type code
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic device_select_pin_low,
  input  wire logic device_select_pin_high,
  input  wire logic write_lock,
  two_wire_if.device bus
);

  // ==========================================================
  // storage and state
  logic [7:0]        mem [MEM_WORDS];          // the array
  slv_state_t        state_q;                  // protocol state
  logic [3:0]        cnt_q;                    // bits moved in this byte
  logic [7:0]        shift_q;                  // received bits
  logic [7:0]        tx_q;                     // byte being sent
  logic [1:0]        idx_q;                    // byte index, saturates
  logic              rw_q;                     // direction of transfer
  logic [ADDR_W-1:0] addr_q;                   // memory pointer
  logic              sda_oe_n_q;               // low while pulling line
  logic              sda_out_q;                // drive value, held low
  logic              scl_prev_q;               // last synced clock
  logic              sda_prev_q;               // last synced data
  logic [4:0]        pins_s;                   // synced inputs
  logic              scl_s;                    // synced clock
  logic              sda_s;                    // synced data
  logic              lock_s;                   // synced write lock
  logic [1:0]        sel_s;                    // synced {high, low} select
  logic              scl_rise;                 // clock rising event
  logic              scl_fall;                 // clock falling event
  logic              start_ev;                 // start condition seen
  logic              stop_ev;                  // stop condition seen
  logic [7:0]        rd_byte;                  // array output at pointer
  logic              wr_en;                    // commit a received byte

  // ==========================================================
  // input synchronisers; floating pins settle low
  line_sync #(.W(5)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({bus.scl, bus.sda, write_lock,
             device_select_pin_high, device_select_pin_low}),
    .q     (pins_s)
  );
  assign scl_s  = pins_s[4];
  assign sda_s  = pins_s[3];
  assign lock_s = pins_s[2];
  assign sel_s  = pins_s[1:0];

  // ==========================================================
  // edge and condition detection on the synced lines
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  // data moving while clock stays high marks a condition
  assign start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // address word check: type code, then select pins high before low
  function automatic logic addr_match(input logic [7:0] b,
                                      input logic [1:0] sel);
    addr_match = (b[7:AW_TYPE_LSB] == TYPE_CODE) &&
                 (b[AW_SELH_BIT] == sel[1]) &&
                 (b[AW_SELL_BIT] == sel[0]);
  endfunction : addr_match

  assign rd_byte = mem[addr_q];
  // data bytes land in the array at the decision edge; the lock
  // blocks them while reads stay untouched
  assign wr_en = (state_q == S_RX) && scl_fall && (cnt_q == 4'(BYTE_W))
                 && (idx_q == 2'h3) && ~rw_q && ~lock_s;

  // ==========================================================
  // array write port; no wait state follows
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr_q] <= shift_q;
    end
  end

  // ==========================================================
  // drive value never changes: the pin only ever pulls low
  always_ff @(posedge clk) begin
    if (reset) begin
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
    end
  end

  // ==========================================================
  // protocol sequencer: conditions first, then clock edges
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q    <= S_IDLE;
      cnt_q      <= 4'h0;
      shift_q    <= 8'h00;
      tx_q       <= 8'h00;
      idx_q      <= 2'h0;
      rw_q       <= 1'b0;
      addr_q     <= '0;
      sda_oe_n_q <= 1'b1;
    end else if (start_ev) begin
      // any start, even mid-byte, restarts address reception
      state_q    <= S_RX;
      cnt_q      <= 4'h0;
      idx_q      <= 2'h0;
      sda_oe_n_q <= 1'b1;
    end else if (stop_ev) begin
      // a stop ends whatever was going on, acked or not
      state_q    <= S_IDLE;
      sda_oe_n_q <= 1'b1;
    end else begin
      case (state_q)
        S_RX: begin
          if (scl_rise && cnt_q < 4'(BYTE_W)) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q   <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'(BYTE_W)) begin
            cnt_q <= 4'h0;
            if (idx_q == 2'h0 && !addr_match(shift_q, sel_s)) begin
              state_q <= S_IDLE;
            end else begin
              // acknowledge on the ninth clock by pulling low
              sda_oe_n_q <= 1'b0;
              state_q    <= S_ACK;
              if (idx_q != 2'h3) begin
                idx_q <= idx_q + 2'h1;
              end
              case (idx_q)
                2'h0: begin
                  rw_q              <= shift_q[AW_DIR_BIT];
                  addr_q[ADDR_W-1]  <= shift_q[AW_TOP_BIT];
                end
                2'h1: addr_q[15:8] <= shift_q;
                2'h2: addr_q[7:0]  <= shift_q;
                default: addr_q    <= addr_q + 1'b1;
              endcase
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            if (rw_q && idx_q == 2'h1) begin
              // read: first data bit goes out as the ack ends
              tx_q       <= rd_byte;
              sda_oe_n_q <= rd_byte[7];
              addr_q     <= addr_q + 1'b1;
              cnt_q      <= 4'h1;
              state_q    <= S_TX;
            end else begin
              sda_oe_n_q <= 1'b1;
              state_q    <= S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'(BYTE_W)) begin
              // let go for the master's acknowledge
              sda_oe_n_q <= 1'b1;
              state_q    <= S_RACK;
            end else begin
              sda_oe_n_q <= tx_q[6];
              tx_q       <= {tx_q[6:0], 1'b0};
              cnt_q      <= cnt_q + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            shift_q[0] <= sda_s;                           // master's answer
          end else if (scl_fall) begin
            if (!shift_q[0]) begin
              tx_q       <= rd_byte;
              sda_oe_n_q <= rd_byte[7];
              addr_q     <= addr_q + 1'b1;
              cnt_q      <= 4'h1;
              state_q    <= S_TX;
            end else begin
              // not-acknowledge: stay off the line until stop or start
              state_q <= S_IDLE;
            end
          end
        end
        S_IDLE: begin
          sda_oe_n_q <= 1'b1;
        end
        default: begin
          state_q    <= S_IDLE;
          sda_oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  assign bus.dev_sda_oe_n = sda_oe_n_q;
  assign bus.dev_sda_out  = sda_out_q;

endmodule : nvram_slave

/* core/nvram_master.sv */
// two-wire bus master driven by apb command registers
`timescale 1ns/100ps
module nvram_master
  import nvram_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  two_wire_if.master       bus
);

  // ==========================================================
  // state
  logic        busy_q;        // an operation is running
  op_t         op_q;          // operation in flight
  logic [1:0]  phase_q;       // step within a bit or condition
  logic [3:0]  bit_q;         // bit of the current byte, 8 is the ack
  logic [7:0]  div_q;         // half-period divider
  logic [8:0]  txd_q;         // byte to send plus released ninth bit
  logic [7:0]  rx_q;          // received byte
  logic        ack_send_q;    // level driven on ninth bit of a read
  logic        nack_q;        // ninth bit sampled high
  logic        scl_q;         // serial clock, push-pull
  logic        sda_oe_n_q;    // low while pulling data line low
  logic        sda_out_q;     // drive value, held low
  logic        sda_s;         // synced data line
  logic        tick;          // half period elapsed
  logic        apb_done;      // access phase completing now
  logic        cmd_wr;        // accepted command write

  line_sync #(.W(1)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     (bus.sda),
    .q     (sda_s)
  );

  // half period sized so the clock never beats the speed limit
  assign tick     = busy_q && (div_q == 8'(SCL_HALF_CYC - 1));
  assign apb_done = psel & penable & pready;
  // commands while busy are dropped; software polls the busy bit
  assign cmd_wr   = apb_done & pwrite & (paddr == CMD_OFF) & ~busy_q;

  // ==========================================================
  // apb slave: zero wait states, answer one edge after setup
  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr != CMD_OFF) &
                 (paddr != TXD_OFF) & (paddr != STAT_OFF);
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (paddr == STAT_OFF) begin
          prdata[STAT_BUSY_BIT]            <= busy_q;
          prdata[STAT_NACK_BIT]            <= nack_q;
          prdata[STAT_RX_LSB +: BYTE_W]    <= rx_q;
        end else if (paddr == TXD_OFF) begin
          prdata[BYTE_W-1:0]               <= txd_q[8:1];
        end
      end
    end
  end

  // ==========================================================
  // half-period divider, only runs during an operation
  always_ff @(posedge clk) begin
    if (reset || !busy_q || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
    end
  end

  // ==========================================================
  // bus sequencer; data only moves while the clock is low except
  // inside start and stop, which move it with the clock high
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_q     <= 1'b0;
      op_q       <= OP_START;
      phase_q    <= 2'h0;
      bit_q      <= 4'h0;
      txd_q      <= TXD_RST;
      rx_q       <= 8'h00;
      ack_send_q <= 1'b0;
      nack_q     <= 1'b0;
      scl_q      <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else if (!busy_q) begin
      if (apb_done && pwrite && paddr == TXD_OFF) begin
        txd_q <= {pwdata[BYTE_W-1:0], 1'b1};
      end
      if (cmd_wr) begin
        busy_q     <= 1'b1;
        op_q       <= op_t'(pwdata[CMD_OP_LSB +: 2]);
        ack_send_q <= pwdata[CMD_ACK_BIT];
        phase_q    <= 2'h0;
        bit_q      <= 4'h0;
      end
    end else if (tick) begin
      phase_q <= phase_q + 2'h1;
      case (op_q)
        OP_START: begin
          // release, clock high, pull data low, clock low
          case (phase_q)
            2'h0: sda_oe_n_q <= 1'b1;
            2'h1: scl_q      <= 1'b1;
            2'h2: sda_oe_n_q <= 1'b0;
            default: begin
              scl_q  <= 1'b0;
              busy_q <= 1'b0;
            end
          endcase
        end
        OP_STOP: begin
          // data low, clock high, release data with clock high
          case (phase_q)
            2'h0: sda_oe_n_q <= 1'b0;
            2'h1: scl_q      <= 1'b1;
            default: begin
              sda_oe_n_q <= 1'b1;
              busy_q     <= 1'b0;
            end
          endcase
        end
        OP_WRITE, OP_READ: begin
          case (phase_q)
            2'h0: begin
              if (op_q == OP_WRITE) begin
                sda_oe_n_q <= txd_q[8];
                txd_q      <= {txd_q[7:0], 1'b1};
              end else begin
                sda_oe_n_q <= (bit_q == 4'(ACK_SLOT)) ? ack_send_q : 1'b1;
              end
            end
            2'h1: scl_q <= 1'b1;
            default: begin
              // sample at the end of the high half, then drop clock
              scl_q   <= 1'b0;
              phase_q <= 2'h0;
              if (bit_q == 4'(ACK_SLOT)) begin
                nack_q <= sda_s;
                busy_q <= 1'b0;
              end else begin
                rx_q  <= {rx_q[6:0], sda_s};
                bit_q <= bit_q + 4'h1;
              end
            end
          endcase
        end
        default: busy_q <= 1'b0;
      endcase
    end
  end

  assign bus.scl          = scl_q;
  assign bus.mst_sda_oe_n = sda_oe_n_q;
  assign bus.mst_sda_out  = sda_out_q;

endmodule : nvram_master

/* tb/nvram_link_checker.sv */
// wire-level checker for the two-wire link between master and slave
`timescale 1ns/100ps
module nvram_link_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n,
  input wire logic mst_sda_out,
  input wire logic mst_sda_oe_n
);
  // ==========================================================
  // bus state tracking
  logic idle_q;                  // high between a stop and the next start
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // stop sets idle, start clears it; both need scl high on two samples
  always_ff @(posedge clk) begin
    if (reset) idle_q <= 1'b1;
    else if (scl && $past(scl) && $rose(sda)) idle_q <= 1'b1;
    else if (scl && $past(scl) && $fell(sda)) idle_q <= 1'b0;
  end
  // ==========================================================
  // wire rules
  a_dev_drive_low: assert property (
    !dev_sda_oe_n |-> !dev_sda_out) else $error("slave drives high");
  a_mst_drive_low: assert property (
    !mst_sda_oe_n |-> !mst_sda_out) else $error("master drives high");
  a_chg_on_low: assert property (
    $changed(dev_sda_oe_n) |-> !scl && !$past(scl))
    else $error("slave moved data with clock high");
  a_hold_high: assert property (
    $rose(scl) && !dev_sda_oe_n |-> !dev_sda_oe_n [*8])
    else $error("slave let go during clock high");
  a_one_driver: assert property (
    $rose(scl) |-> dev_sda_oe_n || mst_sda_oe_n)
    else $error("both ends drive at clock rise");
  a_idle_quiet: assert property (
    idle_q |-> dev_sda_oe_n) else $error("slave drives after stop");
  a_idle_scl_high: assert property (
    idle_q |-> scl) else $error("clock moved while idle");
  a_start_hold: assert property (
    scl && $past(scl) && $fell(sda) |-> scl [*8])
    else $error("clock fell too soon after start");
  a_stop_release: assert property (
    scl && $past(scl) && $rose(sda) |=> dev_sda_oe_n && mst_sda_oe_n)
    else $error("line not free after stop");
endmodule : nvram_link_checker

/* tb/serial_nvram_two_wire_slave_port_tb_top.sv */
// self-checking bench: apb-driven master talking to the memory slave
`timescale 1ns/100ps
module serial_nvram_two_wire_slave_port_tb_top;
  import nvram_pkg::*;
  // ==========================================================
  // signals
  localparam logic [3:0] TC = 4'h6;  // arbitrary type code
  logic        clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;                 // apb address
  logic [31:0] pwdata, prdata, r, s;  // apb data, scratch
  logic        sel_lo, sel_hi, wlock, e; // straps and lock
  logic [16:0] a;                     // memory address under test
  int          failures, check_count, n;
  logic [7:0]  mem [int];             // expected array contents
  two_wire_if link ();
  nvram_master i_nvram_master (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus(link.master));
  nvram_slave #(.TYPE_CODE(TC)) i_nvram_slave (.clk(clk), .reset(reset),
    .device_select_pin_low(sel_lo), .device_select_pin_high(sel_hi),
    .write_lock(wlock), .bus(link.device));
  nvram_link_checker i_nvram_link_checker (.clk(clk), .reset(reset),
    .scl(link.scl), .sda(link.sda), .dev_sda_out(link.dev_sda_out),
    .dev_sda_oe_n(link.dev_sda_oe_n), .mst_sda_out(link.mst_sda_out),
    .mst_sda_oe_n(link.mst_sda_oe_n));
  // ==========================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // a generous bound: the whole sequence needs about 27k to 36k cycles
  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    test_done();
  end
  // ==========================================================
  // helpers
  function automatic logic [7:0] aw(logic [3:0] t, logic [1:0] sl,
                                    logic top, logic dir);
    return {t, sl, top, dir};
  endfunction : aw
  task automatic chk(input string nm, input logic [31:0] x, g);
    check_count++;
    if (g !== x) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // one apb transfer; waits for pready, however long it takes
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic er);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // issue a bus operation and poll until it is no longer busy
  task automatic op(input op_t o, input logic [7:0] b, input logic ak,
                    output logic [31:0] st);
    logic er;
    if (o == OP_WRITE) apb(1'b1, TXD_OFF, {24'h0, b}, st, er);
    apb(1'b1, CMD_OFF, {29'h0, ak, o}, st, er);
    chk("cmd error", 32'h0, {31'h0, er});
    do apb(1'b0, STAT_OFF, 32'h0, st, er);
    while (st[STAT_BUSY_BIT] !== 1'b0);
  endtask : op
  task automatic tx(input logic [7:0] b, input logic nk);
    logic [31:0] st;
    op(OP_WRITE, b, 1'b0, st);
    chk("ninth bit", {31'h0, nk}, {31'h0, st[STAT_NACK_BIT]});
  endtask : tx
  // start, address word for a write, two pointer bytes
  task automatic hdr(input logic [1:0] sl, input logic [16:0] ad);
    op(OP_START, 8'h0, 1'b0, s);
    tx(aw(TC, sl, ad[16], 1'b0), 1'b0);
    tx(ad[15:8], 1'b0);
    tx(ad[7:0], 1'b0);
  endtask : hdr
  task automatic wr(input logic [1:0] sl, input logic [16:0] ad, int cnt);
    logic [7:0] d;
    hdr(sl, ad);
    for (int i = 0; i < cnt; i++) begin
      d = 8'($urandom);
      tx(d, 1'b0);
      if (wlock !== 1'b1) mem[int'(ad) + i] = d;
    end
    op(OP_STOP, 8'h0, 1'b0, s);
  endtask : wr
  // random read with a restart; the last byte is refused by the master
  task automatic rd(input logic [1:0] sl, input logic [16:0] ad, int cnt);
    hdr(sl, ad);
    op(OP_START, 8'h0, 1'b0, s);
    tx(aw(TC, sl, ad[16], 1'b1), 1'b0);
    for (int i = 0; i < cnt; i++) begin
      op(OP_READ, 8'h0, 1'(i == cnt - 1), s);
      chk("read byte", {24'h0, mem[int'(ad) + i]}, {24'h0, s[15:8]});
      chk("read ninth", {31'h0, 1'(i == cnt - 1)},
          {31'h0, s[STAT_NACK_BIT]});
    end
    op(OP_STOP, 8'h0, 1'b0, s);
  endtask : rd
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  // ==========================================================
  // main sequence
  initial begin
    r = $urandom(39);
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; sel_lo = 1'b0; sel_hi = 1'b0; wlock = 1'b0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b1, 12'h00c, 32'h0, s, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    r = $urandom;
    apb(1'b1, TXD_OFF, r, s, e);
    apb(1'b0, TXD_OFF, 32'h0, s, e);
    chk("txd readback", {24'h0, r[7:0]}, {24'h0, s[7:0]});
    // odd passes lock and rewrite the previous pass's bytes
    for (int k = 0; k < 4; k++) begin
      if (k == 0) {sel_hi, sel_lo, wlock} <= 3'bzzz;
      else {sel_hi, sel_lo, wlock} <= {2'(k), k[0]};
      repeat (4) @(posedge clk);
      if (k % 2 == 0) begin
        a = 17'($urandom % (MEM_WORDS - 8));
        n = 1 + $urandom % 3;
      end
      wr(2'(k), a, n);
      rd(2'(k), a, n);
      op(OP_START, 8'h0, 1'b0, s);
      tx(aw(TC, 2'(k) ^ 2'b01, 1'b0, 1'b0), 1'b1);
      op(OP_STOP, 8'h0, 1'b0, s);
      op(OP_START, 8'h0, 1'b0, s);
      tx(aw(TC ^ 4'h1, 2'(k), 1'b0, 1'b0), 1'b1);
      op(OP_STOP, 8'h0, 1'b0, s);
    end
    test_done();
  end
endmodule : serial_nvram_two_wire_slave_port_tb_top
